// *** rtl/fpcs_consts.svh ***
`ifndef FPCS_CONSTS_SVH
`define FPCS_CONSTS_SVH

// register byte addresses
`define FPCS_ADDR_ACCESS_CTRL   32'hE000_ED88
`define FPCS_ADDR_CTX_CTRL      32'hE000_EF34
`define FPCS_ADDR_CTX_ADDR      32'hE000_EF38
`define FPCS_ADDR_DEF_STATUS    32'hE000_EF3C
`define FPCS_ADDR_STATUS_CTRL   32'hE000_EF40

// status and control, context control and access control field positions
`define FPCS_BIT_N              31
`define FPCS_BIT_Z              30
`define FPCS_BIT_C              29
`define FPCS_BIT_V              28
`define FPCS_BIT_AHP            26
`define FPCS_BIT_DN             25
`define FPCS_BIT_FZ             24
`define FPCS_ROUNDING_SELECT_HI           23
`define FPCS_ROUNDING_SELECT_LO           22
`define FPCS_BIT_IDC            7
`define FPCS_EXC_HI             4
`define FPCS_EXC_LO             0
`define FPCS_BIT_LAZY_SAVE_ACTIVE         0
`define FPCS_CP_HI              23
`define FPCS_CP_LO              20

// writable bit masks, everything else reads as zero
`define FPCS_MASK_STATUS_CTRL   32'hF7C0_009F
`define FPCS_MASK_DEF_STATUS    32'h07C0_0000
`define FPCS_MASK_ACCESS_CTRL   32'h00F0_0000
`define FPCS_MASK_CTX_ADDR      32'hFFFF_FFFF
`define FPCS_CP_ALL_ON          4'hF

// reset values
`define FPCS_RST_WORD           32'h0000_0000

`endif

// *** rtl/fpcs_pkg.sv ***
package fpcs_pkg;

   typedef logic [31:0] fpcs_word_t;

   typedef enum logic [1:0] {
      FPCS_RM_NEAREST = 2'h0,
      FPCS_RM_PLUS    = 2'h1,
      FPCS_RM_MINUS   = 2'h2,
      FPCS_RM_ZERO    = 2'h3
   } fpcs_rounding_select_t;

   typedef logic [4:0] fpcs_exc_t;

endpackage : fpcs_pkg

// *** rtl/fpcs_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

// two copies of a register, one per security state
module fpcs_bank #(
   parameter int                  WIDTH = 32,
   parameter logic [WIDTH-1:0]    MASK  = '1,
   parameter logic [WIDTH-1:0]    RST   = '0
) (
   // clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   // software write
   input  wire logic              sw_wr_i,
   input  wire logic              sw_sec_i,
   input  wire logic [WIDTH-1:0]  sw_data_i,
   // hardware load, wins over software in the same copy
   input  wire logic              hw_wr_i,
   input  wire logic              hw_sec_i,
   input  wire logic [WIDTH-1:0]  hw_data_i,
   // copies
   output logic      [WIDTH-1:0]  q_sec_o,
   output logic      [WIDTH-1:0]  q_nsec_o
);

   if (WIDTH < 1) begin : g_bad_width
      $error("fpcs_bank: WIDTH must be at least 1");
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q_sec_o <= RST & MASK;
      end else if (hw_wr_i && hw_sec_i) begin
         q_sec_o <= hw_data_i & MASK;
      end else if (sw_wr_i && sw_sec_i) begin
         q_sec_o <= sw_data_i & MASK;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q_nsec_o <= RST & MASK;
      end else if (hw_wr_i && !hw_sec_i) begin
         q_nsec_o <= hw_data_i & MASK;
      end else if (sw_wr_i && !sw_sec_i) begin
         q_nsec_o <= sw_data_i & MASK;
      end
   end

endmodule : fpcs_bank

`default_nettype wire

// *** rtl/fpcs_regs.sv ***
// Operation
// - lazy save active bit reads 1 while lazy preservation pending, else 0
// - 32-bit context address register, one copy per security state
// - one status and control register shared by both security states
// - floating-point compares update the N, Z, C, V flags
// - two-bit rounding field: nearest, plus inf, minus inf, toward zero
// - flush-to-zero bit 0 gives full IEEE behaviour, 1 enables flushing
// - default NaN bit set returns default NaN, clear propagates NaNs
// - alternative half-precision bit selects conversion format
// - cumulative exception bits set on event, stay until software writes 0
// - separate sticky bit records input-denormal events
// - default-status register per security state holds control defaults
// - new floating-point context loads control fields from default-status
// - unit is disabled from reset until software enables it
// - access control register only reachable while privileged
`timescale 1ns/1ps
`default_nettype none

`include "fpcs_consts.svh"

module fpcs_regs (
   // clock and reset
   input  wire logic                sys_clk_i,
   input  wire logic                rst_i,
   // register access from the core
   input  wire logic                reg_req_i,
   input  wire logic                reg_we_i,
   input  wire logic                reg_priv_i,
   input  wire logic                reg_secure_i,
   input  wire fpcs_pkg::fpcs_word_t reg_addr_i,
   input  wire fpcs_pkg::fpcs_word_t reg_wdata_i,
   output logic                     reg_ack_o,
   output logic                     reg_err_o,
   output fpcs_pkg::fpcs_word_t     reg_rdata_o,
   // lazy preservation events from the core
   input  wire logic                lazy_set_i,
   input  wire logic                lazy_clr_i,
   input  wire logic                ctx_addr_load_i,
   input  wire logic                ctx_addr_secure_i,
   input  wire fpcs_pkg::fpcs_word_t ctx_addr_i,
   // new floating-point context
   input  wire logic                new_ctx_i,
   input  wire logic                new_ctx_secure_i,
   // datapath events
   input  wire logic                cmp_valid_i,
   input  wire logic [3:0]          cmp_nzcv_i,
   input  wire fpcs_pkg::fpcs_exc_t exc_set_i,
   input  wire logic                input_denormal_i,
   // controls to the datapath
   output logic                     fpu_enable_o,
   output fpcs_pkg::fpcs_rounding_select_t    rounding_select_o,
   output logic                     flush_zero_ctrl_o,
   output logic                     default_nan_ctrl_o,
   output logic                     alt_half_format_o,
   output logic                     lazy_save_active_o
);

   import fpcs_pkg::*;

   function automatic logic addr_is(input fpcs_word_t a, input fpcs_word_t b);
      addr_is = (a == b);
   endfunction : addr_is

   // sticky update: an event in the cycle of a clearing write still sets
   function automatic logic sticky(input logic cur, input logic wr, input logic wbit,
                                   input logic ev);
      sticky = ev | (wr ? (cur & wbit) : cur);
   endfunction : sticky

   // the field flops below assume this layout of the header constants
   if (`FPCS_BIT_N - `FPCS_BIT_V != 3) begin : g_bad_flags
      $error("fpcs_regs: condition flags must be four adjacent bits");
   end

   if (`FPCS_ROUNDING_SELECT_HI - `FPCS_ROUNDING_SELECT_LO != 1) begin : g_bad_rounding_select
      $error("fpcs_regs: rounding field must be two bits wide");
   end

   if (`FPCS_BIT_AHP - `FPCS_ROUNDING_SELECT_LO != 4 || `FPCS_BIT_FZ != `FPCS_ROUNDING_SELECT_HI + 1 ||
       `FPCS_BIT_DN != `FPCS_BIT_FZ + 1) begin : g_bad_ctrl
      $error("fpcs_regs: control fields must be one adjacent group");
   end

   if (`FPCS_EXC_HI - `FPCS_EXC_LO != 4) begin : g_bad_exc
      $error("fpcs_regs: cumulative exception field must be five bits wide");
   end

   if (`FPCS_CP_HI - `FPCS_CP_LO != 3) begin : g_bad_cp
      $error("fpcs_regs: coprocessor access field must be four bits wide");
   end

   if ((`FPCS_MASK_DEF_STATUS & ~`FPCS_MASK_STATUS_CTRL) != 32'h0000_0000) begin : g_bad_mask
      $error("fpcs_regs: default-status bits must all exist in status");
   end

   if (`FPCS_BIT_IDC <= `FPCS_EXC_HI || `FPCS_BIT_IDC >= `FPCS_ROUNDING_SELECT_LO) begin : g_bad_idc
      $error("fpcs_regs: input-denormal bit must sit between the field groups");
   end

   logic [3:0]  flags_ff;
   logic [3:0]  nxt_flags;
   logic [4:0]  ctrl_ff;
   logic [4:0]  nxt_ctrl;
   fpcs_exc_t   exc_ff;
   fpcs_exc_t   nxt_exc;
   logic        idc_ff;
   logic        nxt_idc;
   fpcs_word_t  status_word;
   logic        st_wr;
   fpcs_word_t  access_ctrl_ff;
   fpcs_word_t  nxt_access_ctrl;
   logic        lazy_active_ff;
   logic        nxt_lazy_active;
   logic        fpu_enable_ff;
   logic        ack_ff;
   logic        err_ff;
   fpcs_word_t  rdata_ff;
   fpcs_word_t  nxt_rdata;
   logic        nxt_err;

   logic        hit_access;
   logic        hit_ctx_ctrl;
   logic        hit_ctx_addr;
   logic        hit_def;
   logic        hit_status;
   logic        allowed;
   logic        wr_ok;
   fpcs_word_t  ctx_addr_sec;
   fpcs_word_t  ctx_addr_nsec;
   fpcs_word_t  def_sec;
   fpcs_word_t  def_nsec;
   fpcs_word_t  def_sel;

   // address decode and access checks
   always_comb begin
      hit_access   = addr_is(reg_addr_i, `FPCS_ADDR_ACCESS_CTRL);
      hit_ctx_ctrl = addr_is(reg_addr_i, `FPCS_ADDR_CTX_CTRL);
      hit_ctx_addr = addr_is(reg_addr_i, `FPCS_ADDR_CTX_ADDR);
      hit_def      = addr_is(reg_addr_i, `FPCS_ADDR_DEF_STATUS);
      hit_status   = addr_is(reg_addr_i, `FPCS_ADDR_STATUS_CTRL);
      allowed      = 1'b0;
      if (hit_access || hit_ctx_ctrl || hit_ctx_addr || hit_def) begin
         allowed = reg_priv_i;
      end else if (hit_status) begin
         allowed = fpu_enable_ff;
      end
      wr_ok = reg_req_i && reg_we_i && allowed;
   end

   // context address, banked by security state
   fpcs_bank #(
      .WIDTH (32),
      .MASK  (`FPCS_MASK_CTX_ADDR),
      .RST   (`FPCS_RST_WORD)
   ) u_ctx_addr (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .sw_wr_i   (wr_ok && hit_ctx_addr),
      .sw_sec_i  (reg_secure_i),
      .sw_data_i (reg_wdata_i),
      .hw_wr_i   (ctx_addr_load_i),
      .hw_sec_i  (ctx_addr_secure_i),
      .hw_data_i (ctx_addr_i),
      .q_sec_o   (ctx_addr_sec),
      .q_nsec_o  (ctx_addr_nsec)
   );

   // default-status, banked by security state
   fpcs_bank #(
      .WIDTH (32),
      .MASK  (`FPCS_MASK_DEF_STATUS),
      .RST   (`FPCS_RST_WORD)
   ) u_def_status (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .sw_wr_i   (wr_ok && hit_def),
      .sw_sec_i  (reg_secure_i),
      .sw_data_i (reg_wdata_i),
      .hw_wr_i   (1'b0),
      .hw_sec_i  (1'b0),
      .hw_data_i (`FPCS_RST_WORD),
      .q_sec_o   (def_sec),
      .q_nsec_o  (def_nsec)
   );

   assign def_sel = new_ctx_secure_i ? def_sec : def_nsec;

   // status and control, one copy for both states, one flop per field group
   assign st_wr = wr_ok && hit_status;

   // condition flags: a compare beats a software write in the same cycle
   always_comb begin
      nxt_flags = flags_ff;
      if (st_wr) begin
         nxt_flags = reg_wdata_i[`FPCS_BIT_N:`FPCS_BIT_V];
      end
      if (cmp_valid_i && fpu_enable_ff) begin
         nxt_flags = cmp_nzcv_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         flags_ff <= 4'h0;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // control fields: a new context beats a software write in the same cycle
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (st_wr) begin
         nxt_ctrl = reg_wdata_i[`FPCS_BIT_AHP:`FPCS_ROUNDING_SELECT_LO];
      end
      if (new_ctx_i) begin
         nxt_ctrl = def_sel[`FPCS_BIT_AHP:`FPCS_ROUNDING_SELECT_LO];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_ff <= 5'h00;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // cumulative exceptions: an event beats a clearing write in the same cycle
   always_comb begin
      for (int i = 0; i <= `FPCS_EXC_HI - `FPCS_EXC_LO; i++) begin
         nxt_exc[i] = sticky(exc_ff[i], st_wr, reg_wdata_i[`FPCS_EXC_LO + i],
                             exc_set_i[i] && fpu_enable_ff);
      end
      nxt_idc = sticky(idc_ff, st_wr, reg_wdata_i[`FPCS_BIT_IDC],
                       input_denormal_i && fpu_enable_ff);
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         exc_ff <= 5'h00;
         idc_ff <= 1'b0;
      end else begin
         exc_ff <= nxt_exc;
         idc_ff <= nxt_idc;
      end
   end

   // assembled word, reserved bits read zero
   always_comb begin
      status_word = `FPCS_RST_WORD;
      status_word[`FPCS_BIT_N:`FPCS_BIT_V] = flags_ff;
      status_word[`FPCS_BIT_AHP:`FPCS_ROUNDING_SELECT_LO] = ctrl_ff;
      status_word[`FPCS_BIT_IDC] = idc_ff;
      status_word[`FPCS_EXC_HI:`FPCS_EXC_LO] = exc_ff;
   end

   // controls driven straight from the field flops
   assign rounding_select_o  = fpcs_rounding_select_t'(ctrl_ff[`FPCS_ROUNDING_SELECT_HI - `FPCS_ROUNDING_SELECT_LO:0]);
   assign flush_zero_ctrl_o  = ctrl_ff[`FPCS_BIT_FZ - `FPCS_ROUNDING_SELECT_LO];
   assign default_nan_ctrl_o = ctrl_ff[`FPCS_BIT_DN - `FPCS_ROUNDING_SELECT_LO];
   assign alt_half_format_o  = ctrl_ff[`FPCS_BIT_AHP - `FPCS_ROUNDING_SELECT_LO];

   // coprocessor access control
   always_comb begin
      nxt_access_ctrl = access_ctrl_ff;
      if (wr_ok && hit_access) begin
         nxt_access_ctrl = reg_wdata_i & `FPCS_MASK_ACCESS_CTRL;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         access_ctrl_ff <= `FPCS_RST_WORD;
      end else begin
         access_ctrl_ff <= nxt_access_ctrl;
      end
   end

   // unit usable only once all four access bits are set
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         fpu_enable_ff <= 1'b0;
      end else begin
         fpu_enable_ff <= (nxt_access_ctrl[`FPCS_CP_HI:`FPCS_CP_LO] == `FPCS_CP_ALL_ON);
      end
   end

   assign fpu_enable_o = fpu_enable_ff;

   // lazy preservation active, hardware set beats any clear
   always_comb begin
      nxt_lazy_active = lazy_active_ff;
      if (lazy_clr_i) begin
         nxt_lazy_active = 1'b0;
      end
      if (wr_ok && hit_ctx_ctrl) begin
         nxt_lazy_active = reg_wdata_i[`FPCS_BIT_LAZY_SAVE_ACTIVE];
      end
      if (lazy_set_i) begin
         nxt_lazy_active = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         lazy_active_ff <= 1'b0;
      end else begin
         lazy_active_ff <= nxt_lazy_active;
      end
   end

   assign lazy_save_active_o = lazy_active_ff;

   // read data and response
   always_comb begin
      nxt_rdata = `FPCS_RST_WORD;
      nxt_err   = !allowed;
      if (allowed) begin
         if (hit_access) begin
            nxt_rdata = access_ctrl_ff;
         end else if (hit_ctx_ctrl) begin
            nxt_rdata[`FPCS_BIT_LAZY_SAVE_ACTIVE] = lazy_active_ff;
         end else if (hit_ctx_addr) begin
            nxt_rdata = reg_secure_i ? ctx_addr_sec : ctx_addr_nsec;
         end else if (hit_def) begin
            nxt_rdata = reg_secure_i ? def_sec : def_nsec;
         end else if (hit_status) begin
            nxt_rdata = status_word & `FPCS_MASK_STATUS_CTRL;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ack_ff   <= 1'b0;
         err_ff   <= 1'b0;
         rdata_ff <= `FPCS_RST_WORD;
      end else begin
         ack_ff   <= reg_req_i;
         err_ff   <= reg_req_i && nxt_err;
         rdata_ff <= (reg_req_i && !reg_we_i) ? nxt_rdata : `FPCS_RST_WORD;
      end
   end

   assign reg_ack_o   = ack_ff;
   assign reg_err_o   = err_ff;
   assign reg_rdata_o = rdata_ff;

endmodule : fpcs_regs

`default_nettype wire

// *** sim/fpcs_regs_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fpcs_consts.svh"
module fpcs_regs_chk (
   // watched ports
   input wire logic                  sys_clk_i,
   input wire logic                  rst_i,
   input wire logic                  reg_req_i,
   input wire logic                  reg_we_i,
   input wire logic                  reg_priv_i,
   input wire fpcs_pkg::fpcs_word_t  reg_addr_i,
   input wire fpcs_pkg::fpcs_word_t  reg_wdata_i,
   input wire logic                  reg_ack_o,
   input wire logic                  reg_err_o,
   input wire logic                  lazy_set_i,
   input wire logic                  lazy_clr_i,
   input wire logic                  new_ctx_i,
   input wire logic                  fpu_enable_o,
   input wire fpcs_pkg::fpcs_rounding_select_t rounding_select_o,
   input wire logic                  lazy_save_active_o
);
   import fpcs_pkg::*;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   logic sc;
   logic prv;
   assign sc = reg_req_i && reg_addr_i == `FPCS_ADDR_STATUS_CTRL;
   assign prv = reg_req_i && !reg_priv_i && reg_addr_i inside {`FPCS_ADDR_ACCESS_CTRL,
      `FPCS_ADDR_CTX_CTRL, `FPCS_ADDR_CTX_ADDR, `FPCS_ADDR_DEF_STATUS};
   a_ack_after_req: assert property (reg_req_i |=> reg_ack_o)
      else $error("ack missing after request");
   a_ack_only_req: assert property (!reg_req_i |=> !reg_ack_o)
      else $error("ack without request");
   a_err_unpriv: assert property (prv |=> reg_err_o && reg_ack_o)
      else $error("unprivileged access not refused");
   a_err_disabled: assert property (sc && !fpu_enable_o |=> reg_err_o)
      else $error("status access while disabled not refused");
   a_status_ok: assert property (sc && fpu_enable_o |=> !reg_err_o)
      else $error("status access refused while enabled");
   a_enable_set: assert property (reg_req_i && reg_we_i && reg_priv_i && reg_addr_i ==
      `FPCS_ADDR_ACCESS_CTRL && reg_wdata_i[23:20] == 4'hF |=> fpu_enable_o)
      else $error("unit not enabled by access write");
   a_lazy_set: assert property (lazy_set_i |=> lazy_save_active_o)
      else $error("lazy flag not set");
   a_lazy_hold: assert property (!lazy_set_i && !lazy_clr_i && !reg_req_i
      |=> $stable(lazy_save_active_o))
      else $error("lazy flag changed without cause");
   a_rounding_select_hold: assert property (!reg_req_i && !new_ctx_i |=> $stable(rounding_select_o))
      else $error("rounding changed without cause");
   c_enable: cover property ($rose(fpu_enable_o));
   c_err: cover property (reg_err_o);
   c_new_ctx: cover property (new_ctx_i ##1 rounding_select_o == FPCS_RM_ZERO);
endmodule : fpcs_regs_chk
`default_nettype wire

// *** sim/fpcs_sw_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fpcs_consts.svh"
// core software running the privileged unit enable sequence
module fpcs_sw_model (
   // clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_i,
   // sequence control
   input  wire logic                 start_i,
   output logic                      busy_o,
   // register access
   input  wire logic                 reg_ack_i,
   input  wire fpcs_pkg::fpcs_word_t reg_rdata_i,
   output logic                      reg_req_o,
   output logic                      reg_we_o,
   output fpcs_pkg::fpcs_word_t      reg_addr_o,
   output fpcs_pkg::fpcs_word_t      reg_wdata_o
);
   import fpcs_pkg::*;
   logic [2:0] st_ff;
   assign busy_o = st_ff != 3'h0;
   assign reg_addr_o = `FPCS_ADDR_ACCESS_CTRL;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_ff <= 3'h0;
         reg_req_o <= 1'b0;
         reg_we_o <= 1'b0;
         reg_wdata_o <= '0;
      end else begin
         reg_req_o <= 1'b0;
         case (st_ff)
            3'h0: if (start_i) begin
               reg_req_o <= 1'b1;
               reg_we_o <= 1'b0;
               st_ff <= 3'h1;
            end
            3'h1: if (reg_ack_i) begin
               reg_req_o <= 1'b1;
               reg_we_o <= 1'b1;
               reg_wdata_o <= reg_rdata_i | {8'h00, `FPCS_CP_ALL_ON, 20'h0_0000};
               st_ff <= 3'h2;
            end
            3'h2: if (reg_ack_i) st_ff <= 3'h3;
            // idle cycles stand for the barriers before the unit is used
            default: st_ff <= st_ff + 3'h1;
         endcase
      end
   end
endmodule : fpcs_sw_model
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fpcs_consts.svh"
module testbench;
   import fpcs_pkg::*;
   localparam fpcs_word_t AC = `FPCS_ADDR_ACCESS_CTRL;
   localparam fpcs_word_t SC = `FPCS_ADDR_STATUS_CTRL;
   localparam fpcs_word_t DS = `FPCS_ADDR_DEF_STATUS;
   localparam fpcs_word_t CA = `FPCS_ADDR_CTX_ADDR;
   localparam fpcs_word_t CC = `FPCS_ADDR_CTX_CTRL;
   typedef struct packed {logic w; logic p; logic s; fpcs_word_t a, d, r; logic e;} fpcs_row_t;
   logic clk, rst, t_req, t_we, t_priv, t_sec, lset, lclr, cal, cas, nc, ncs, cv, idn, start;
   logic ack, err, en, fz, dn, alt_half_format, lz, m_req, m_we, m_busy;
   logic [3:0] nzcv;
   fpcs_exc_t exc;
   fpcs_rounding_select_t rm;
   fpcs_word_t t_addr, t_wdata, cad, rdata, m_addr, m_wdata;
   int fail_count, checks_done;
   fpcs_row_t rows [13] = '{'{1,0,0,SC,'1,0,0}, '{0,0,0,SC,0,32'hF7C0_0000,0},
      '{1,0,0,SC,0,0,0}, '{1,1,1,DS,'1,0,0}, '{0,1,1,DS,0,32'h07C0_0000,0},
      '{0,1,0,DS,0,0,0}, '{1,1,0,CA,32'h1234_5678,0,0}, '{0,1,0,CA,0,32'h1234_5678,0},
      '{0,1,1,CA,0,0,0}, '{0,0,0,AC,0,0,1}, '{0,1,0,AC,0,32'h00F0_0000,0},
      '{0,1,0,32'hE000_EF44,0,0,1}, '{1,0,0,CC,1,0,1}};
   fpcs_regs u_dut (.sys_clk_i(clk), .rst_i(rst), .reg_req_i(t_req | m_req),
      .reg_we_i(m_busy ? m_we : t_we), .reg_priv_i(t_priv | m_busy), .reg_secure_i(t_sec),
      .reg_addr_i(m_busy ? m_addr : t_addr), .reg_wdata_i(m_busy ? m_wdata : t_wdata),
      .reg_ack_o(ack), .reg_err_o(err), .reg_rdata_o(rdata), .lazy_set_i(lset),
      .lazy_clr_i(lclr), .ctx_addr_load_i(cal), .ctx_addr_secure_i(cas), .ctx_addr_i(cad),
      .new_ctx_i(nc), .new_ctx_secure_i(ncs), .cmp_valid_i(cv), .cmp_nzcv_i(nzcv),
      .exc_set_i(exc), .input_denormal_i(idn), .fpu_enable_o(en), .rounding_select_o(rm),
      .flush_zero_ctrl_o(fz), .default_nan_ctrl_o(dn), .alt_half_format_o(alt_half_format),
      .lazy_save_active_o(lz));
   fpcs_sw_model u_sw (.sys_clk_i(clk), .rst_i(rst), .start_i(start), .busy_o(m_busy),
      .reg_ack_i(ack), .reg_rdata_i(rdata), .reg_req_o(m_req), .reg_we_o(m_we),
      .reg_addr_o(m_addr), .reg_wdata_o(m_wdata));
   task automatic chk(input string n, input fpcs_word_t s, x);
      checks_done++;
      if (s !== x) begin
         $display("Error %s expected %h seen %h", n, x, s);
         fail_count++;
      end
   endtask : chk
   task automatic acc(input logic w, p, s, input fpcs_word_t a, d, r, input logic e);
      @(posedge clk);
      {t_req, t_we, t_priv, t_sec} <= {1'b1, w, p, s};
      t_addr <= a;
      t_wdata <= d;
      @(posedge clk);
      t_req <= 1'b0;
      #1;
      chk("ack", 32'(ack), 1);
      chk("err", 32'(err), 32'(e));
      chk("rdata", rdata, r);
   endtask : acc
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      summarize();
   end
   initial begin
      {t_req, t_we, t_priv, t_sec, lset, lclr, cal, cas, nc, ncs, cv, idn, start} = '0;
      {nzcv, exc, t_addr, t_wdata, cad} = '0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1 chk("rst", 32'({en, lz, rm}), 0);
      acc(0, 0, 0, SC, 0, 0, 1);
      acc(1, 1, 1, CC, 0, 0, 0);
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 20 && m_busy; k++) @(posedge clk);
      chk("en", 32'(en), 1);
      foreach (rows[i]) acc(rows[i].w, rows[i].p, rows[i].s, rows[i].a, rows[i].d,
         rows[i].r, rows[i].e);
      for (int i = 0; i < 4; i++) begin
         acc(1, 0, 0, SC, (32'(i) << 22) | (32'(i) << 24) | (32'(i & 1) << 26), 0, 0);
         chk("ctl", 32'({alt_half_format, dn, fz, rm}), 32'({i[0], i[1], i[0], 2'(i)}));
      end
      acc(1, 0, 0, SC, 0, 0, 0);
      @(posedge clk);
      {cv, idn, nzcv, exc} <= {2'b11, 4'hA, 5'h15};
      @(posedge clk);
      {cv, idn, exc} <= '0;
      acc(0, 0, 0, SC, 0, 32'hA000_0095, 0);
      acc(0, 0, 0, SC, 0, 32'hA000_0095, 0);
      acc(1, 0, 0, SC, 0, 0, 0);
      acc(0, 0, 0, SC, 0, 0, 0);
      @(posedge clk);
      {nc, ncs} <= 2'b11;
      @(posedge clk);
      nc <= 1'b0;
      #1 chk("ctl", 32'({alt_half_format, dn, fz, rm}), 32'h1F);
      acc(0, 0, 0, SC, 0, 32'h07C0_0000, 0);
      @(posedge clk);
      {nc, ncs} <= 2'b10;
      @(posedge clk);
      nc <= 1'b0;
      acc(0, 0, 0, SC, 0, 0, 0);
      @(posedge clk);
      lset <= 1'b1;
      @(posedge clk);
      lset <= 1'b0;
      #1 chk("lazy", 32'(lz), 1);
      @(posedge clk);
      lclr <= 1'b1;
      @(posedge clk);
      lclr <= 1'b0;
      #1 chk("lazy", 32'(lz), 0);
      @(posedge clk);
      {cal, cas, cad} <= {2'b11, 32'hCAFE_0010};
      @(posedge clk);
      cal <= 1'b0;
      acc(0, 1, 1, CA, 0, 32'hCAFE_0010, 0);
      acc(0, 1, 0, CA, 0, 32'h1234_5678, 0);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      #1 chk("rst2", 32'({en, lz, rm}), 0);
      acc(0, 1, 0, CA, 0, 0, 0);
      summarize();
   end
endmodule : testbench
bind fpcs_regs fpcs_regs_chk u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
   .reg_req_i(reg_req_i), .reg_we_i(reg_we_i), .reg_priv_i(reg_priv_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_ack_o(reg_ack_o),
   .reg_err_o(reg_err_o), .lazy_set_i(lazy_set_i), .lazy_clr_i(lazy_clr_i),
   .new_ctx_i(new_ctx_i), .fpu_enable_o(fpu_enable_o),
   .rounding_select_o(rounding_select_o), .lazy_save_active_o(lazy_save_active_o));
`default_nettype wire
